// ==== src/tqec_pkg.sv ====
// Package for the thread qualified event counter pair: register map,
// field positions, reset values and the carrier structs.
// Assumes one core clock and a single register access port.
package tqec_pkg;

  // Register map, by register index
  localparam logic [11:0] ADDR_CFG0 = 12'h370;
  localparam logic [11:0] ADDR_CFG1 = 12'h371;
  localparam logic [11:0] ADDR_CNT0 = 12'h3a0;
  localparam logic [11:0] ADDR_CNT1 = 12'h3a1;
  localparam logic [11:0] ADDR_PSEN = 12'h3f1;

  // Counter configuration fields
  localparam int EN_BIT = 12;
  localparam int SEL_LSB = 13;
  localparam int ACT_LSB = 16;
  localparam int CMP_BIT = 18;
  localparam int CMPL_BIT = 19;
  localparam int THR_LSB = 20;
  localparam int EDGE_BIT = 24;
  localparam int FOVF_BIT = 25;
  localparam int IRQ0_BIT = 26;
  localparam int IRQ1_BIT = 27;
  localparam int CASC_BIT = 30;
  localparam int OVF_BIT = 31;

  // Precise sampling enable fields
  localparam int PS_OWN_BIT = 25;
  localparam int PS_SIB_BIT = 26;

  // Event selection qualifier bits
  localparam int Q_THREAD1_USER_LEVEL_QUAL = 0;
  localparam int Q_THREAD1_KERNEL_LEVEL_QUAL = 1;
  localparam int Q_THREAD0_USER_LEVEL_QUAL = 2;
  localparam int Q_THREAD0_KERNEL_LEVEL_QUAL = 3;

  // Active thread encodings
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_SINGLE = 2'h1;
  localparam logic [1:0] ACT_BOTH = 2'h2;
  localparam logic [1:0] ACT_ANY = 2'h3;

  // Reset values
  localparam logic [1:0] PSEN_RST = 2'h0;
  localparam logic [63:0] RDATA_RST = 64'h0;

  typedef struct packed {
    logic ovf;
    logic casc;
    logic irq1;
    logic irq0;
    logic fovf;
    logic edge_en;
    logic [3:0] thr;
    logic cmpl;
    logic cmp;
    logic [1:0] act;
    logic [2:0] sel;
    logic en;
  } tqec_cfg_t;

  localparam tqec_cfg_t CFG_RST = '0;

  // One logical processor as seen by the pipeline
  typedef struct packed {
    logic [7:0] interrupt_controller_unit_id;
    logic halted;
    logic wait_startup_interprocessor_interrupt;
    logic kernel;
  } tqec_slot_t;

  // One event selector: qualifiers and per-cycle counts
  typedef struct packed {
    logic [3:0] qual;
    logic ti;
    logic precise;
    logic [3:0] cnt_t0;
    logic [3:0] cnt_t1;
    logic [3:0] cnt_ti;
  } tqec_sel_t;

  // Register access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [63:0] wdata;
    logic [7:0] src_interrupt_controller_unit_id;
  } tqec_msr_t;

endpackage : tqec_pkg

// ==== src/tqec_ctrl.sv ====
// Configuration and control of a cascadable pair of event counters
// in a two thread processor, with precise sampling enables.
// Assumes event sources and register requests on mclk_i.
`timescale 1ns/1ps

module tqec_ctrl
  import tqec_pkg::*;
#(
  parameter int CNT_W = 40,
  parameter int NSEL = 8
) (
  input wire logic mclk_i,               // Core clock, 40 MHz
  input wire logic resetn_i,             // Async reset, active low
  input wire tqec_msr_t msr_i,           // Register request
  output logic [63:0] msr_rdata_o,       // Read data
  output logic msr_ack_o,                // Request done pulse
  input wire tqec_slot_t slot_i [2],     // Logical processor state
  input wire tqec_sel_t sel_i [NSEL],    // Event selector inputs
  output logic irq_lp0_o,                // Interrupt pulse to lp0
  output logic irq_lp1_o,                // Interrupt pulse to lp1
  output logic [1:0] ps_sample_o,        // Precise sample pulse per lp
  output logic [1:0] ovf_flag_o          // Sticky overflow per counter
);

  // Index of the slot that holds thread t
  function automatic logic slot_of(input logic t,
                                   input logic id0_bit0);
    slot_of = (id0_bit0 == t) ? 1'b0 : 1'b1;
  endfunction : slot_of

  // Qualified per-cycle count of one selector
  function automatic logic [4:0] sel_count(input tqec_sel_t s,
                                           input logic [1:0] kern);
    logic t0_hit;
    logic t1_hit;
    logic m_os;
    logic m_usr;
    logic ti_hit;
    t0_hit = (s.qual[Q_THREAD0_KERNEL_LEVEL_QUAL] & kern[0]) |
             (s.qual[Q_THREAD0_USER_LEVEL_QUAL] & ~kern[0]);
    t1_hit = (s.qual[Q_THREAD1_KERNEL_LEVEL_QUAL] & kern[1]) |
             (s.qual[Q_THREAD1_USER_LEVEL_QUAL] & ~kern[1]);
    m_os = s.qual[Q_THREAD0_KERNEL_LEVEL_QUAL] | s.qual[Q_THREAD1_KERNEL_LEVEL_QUAL];
    m_usr = s.qual[Q_THREAD0_USER_LEVEL_QUAL] | s.qual[Q_THREAD1_USER_LEVEL_QUAL];
    ti_hit = (m_os & m_usr) |
             (m_os & (kern[0] | kern[1])) |
             (m_usr & ~(kern[0] & kern[1]));
    if (s.ti) begin
      sel_count = ti_hit ? {1'b0, s.cnt_ti} : 5'h00;
    end else begin
      // Each thread gated by its own bits only
      sel_count = (t0_hit ? {1'b0, s.cnt_t0} : 5'h00) +
                  (t1_hit ? {1'b0, s.cnt_t1} : 5'h00);
    end
  endfunction : sel_count

  // Active-thread filter
  function automatic logic act_ok(input logic [1:0] mode,
                                  input logic [1:0] act);
    unique case (mode)
      ACT_NONE: act_ok = ~(act[0] | act[1]);
      ACT_SINGLE: act_ok = act[0] ^ act[1];
      ACT_BOTH: act_ok = act[0] & act[1];
      ACT_ANY: act_ok = act[0] | act[1];
    endcase
  endfunction : act_ok

  // Configuration register as a 64-bit word, reserved bits zero
  function automatic logic [63:0] cfg_word(input tqec_cfg_t c);
    logic [63:0] w;
    w = 64'h0;
    w[EN_BIT] = c.en;
    w[SEL_LSB +: 3] = c.sel;
    w[ACT_LSB +: 2] = c.act;
    w[CMP_BIT] = c.cmp;
    w[CMPL_BIT] = c.cmpl;
    w[THR_LSB +: 4] = c.thr;
    w[EDGE_BIT] = c.edge_en;
    w[FOVF_BIT] = c.fovf;
    w[IRQ0_BIT] = c.irq0;
    w[IRQ1_BIT] = c.irq1;
    w[CASC_BIT] = c.casc;
    w[OVF_BIT] = c.ovf;
    cfg_word = w;
  endfunction : cfg_word

  // Thread view of the two slots
  wire logic id0_bit0 = slot_i[0].interrupt_controller_unit_id[0];
  wire logic [1:0] th_kern;
  wire logic [1:0] th_act;
  wire logic wr_own = msr_i.src_interrupt_controller_unit_id[0];

  for (genvar t = 0; t < 2; t++) begin : g_thr
    wire logic s = slot_of(1'(t), id0_bit0);
    assign th_kern[t] = slot_i[s].kernel;
    assign th_act[t] = ~slot_i[s].halted &
                       ~slot_i[s].wait_startup_interprocessor_interrupt;
  end

  // Register decode
  wire logic wr_cfg0 = msr_i.wr & (msr_i.addr == ADDR_CFG0);
  wire logic wr_cfg1 = msr_i.wr & (msr_i.addr == ADDR_CFG1);
  wire logic wr_cnt0 = msr_i.wr & (msr_i.addr == ADDR_CNT0);
  wire logic wr_cnt1 = msr_i.wr & (msr_i.addr == ADDR_CNT1);
  wire logic wr_psen = msr_i.wr & (msr_i.addr == ADDR_PSEN);
  wire logic [1:0] wr_cfg = {wr_cfg1, wr_cfg0};
  wire logic [1:0] wr_cnt = {wr_cnt1, wr_cnt0};

  // Shared per-counter results
  tqec_cfg_t cfg_q [2];
  wire logic [CNT_W-1:0] cnt_q [2];
  wire logic [1:0] ovf_ev;
  wire logic [1:0] fire0;
  wire logic [1:0] fire1;
  wire logic [1:0] ps_fire;

  // Precise sampling enables, indexed by logical processor
  logic [1:0] ps_en_reg;
  logic [1:0] ps_en_next;

  // A write names threads relative to the writer, never by ID
  always_comb begin
    ps_en_next = ps_en_reg;
    if (wr_psen) begin
      ps_en_next[wr_own] = msr_i.wdata[PS_OWN_BIT];
      ps_en_next[~wr_own] = msr_i.wdata[PS_SIB_BIT];
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_cnt
    tqec_cfg_t cfg_reg;
    tqec_cfg_t cfg_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic prev_reg;
    logic armed_reg;
    logic pend_reg;

    wire tqec_sel_t sel = sel_i[cfg_reg.sel];
    wire logic [4:0] raw = sel_count(sel, th_kern);
    wire logic [4:0] thr5 = {1'b0, cfg_reg.thr};
    wire logic hit = cfg_reg.cmpl ? (raw <= thr5) :
                                    (raw > thr5);
    wire logic hit_q = cfg_reg.edge_en ?
                       (hit & ~prev_reg) : hit;
    // Without compare the raw count passes untouched
    wire logic [4:0] inc = cfg_reg.cmp ? {4'h0, hit_q} : raw;
    wire logic alt_ovf = ovf_ev[1 - c];
    wire logic go = cfg_reg.en &
                    act_ok(cfg_reg.act, th_act) &
                    (~cfg_reg.casc | armed_reg);
    wire logic [4:0] add = go ? inc : 5'h00;
    wire logic stepped = (add != 5'h00);
    wire logic [CNT_W:0] sum = {1'b0, cnt_reg} +
                               {{(CNT_W - 4){1'b0}}, add};
    wire logic wrap = sum[CNT_W];
    assign ovf_ev[c] = stepped &
                       (cfg_reg.fovf | wrap);

    // Interrupt waits for the next count after overflow
    wire logic fire = pend_reg & stepped;
    assign fire0[c] = fire & cfg_reg.irq0;
    assign fire1[c] = fire & cfg_reg.irq1;
    // Counter c samples for processor c
    assign ps_fire[c] = ovf_ev[c] & ps_en_reg[c] & sel.precise;

    always_comb begin
      cfg_next = cfg_reg;
      if (wr_cfg[c]) begin
        cfg_next.en = msr_i.wdata[EN_BIT];
        cfg_next.sel = msr_i.wdata[SEL_LSB +: 3];
        cfg_next.act = msr_i.wdata[ACT_LSB +: 2];
        cfg_next.cmp = msr_i.wdata[CMP_BIT];
        cfg_next.cmpl = msr_i.wdata[CMPL_BIT];
        cfg_next.thr = msr_i.wdata[THR_LSB +: 4];
        cfg_next.edge_en = msr_i.wdata[EDGE_BIT];
        cfg_next.fovf = msr_i.wdata[FOVF_BIT];
        cfg_next.irq0 = msr_i.wdata[IRQ0_BIT];
        cfg_next.irq1 = msr_i.wdata[IRQ1_BIT];
        cfg_next.casc = msr_i.wdata[CASC_BIT];
        cfg_next.ovf = msr_i.wdata[OVF_BIT];
      end
      // Overflow beats a clearing write in the same cycle
      if (ovf_ev[c]) begin
        cfg_next.ovf = 1'b1;
      end
    end

    // Software write of the count wins over an increment
    assign cnt_next = wr_cnt[c] ? msr_i.wdata[CNT_W-1:0] :
                                  sum[CNT_W-1:0];

    always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        cfg_reg <= CFG_RST;
        cnt_reg <= '0;
        prev_reg <= 1'b0;
        armed_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else begin
        cfg_reg <= cfg_next;
        cnt_reg <= cnt_next;
        prev_reg <= hit & cfg_reg.cmp;
        // Arm stays until cascading is turned off
        armed_reg <= cfg_reg.casc & (armed_reg | alt_ovf);
        pend_reg <= ovf_ev[c] | (pend_reg & ~stepped);
      end
    end

    assign cfg_q[c] = cfg_reg;
    assign cnt_q[c] = cnt_reg;
  end

  // Read mux; unmapped addresses read zero
  wire logic rd_own = msr_i.src_interrupt_controller_unit_id[0];
  logic [63:0] rd_word;

  always_comb begin
    rd_word = 64'h0;
    unique case (msr_i.addr)
      ADDR_CFG0: rd_word = cfg_word(cfg_q[0]);
      ADDR_CFG1: rd_word = cfg_word(cfg_q[1]);
      ADDR_CNT0: rd_word[CNT_W-1:0] = cnt_q[0];
      ADDR_CNT1: rd_word[CNT_W-1:0] = cnt_q[1];
      ADDR_PSEN: begin
        rd_word[PS_OWN_BIT] = ps_en_reg[rd_own];
        rd_word[PS_SIB_BIT] = ps_en_reg[~rd_own];
      end
      default: rd_word = 64'h0;
    endcase
  end

  logic [63:0] rdata_reg;
  logic ack_reg;
  logic irq0_reg;
  logic irq1_reg;
  logic [1:0] ps_reg;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ps_en_reg <= PSEN_RST;
      rdata_reg <= RDATA_RST;
      ack_reg <= 1'b0;
      irq0_reg <= 1'b0;
      irq1_reg <= 1'b0;
      ps_reg <= 2'h0;
    end else begin
      ps_en_reg <= ps_en_next;
      if (msr_i.rd) begin
        rdata_reg <= rd_word;
      end
      ack_reg <= msr_i.rd | msr_i.wr;
      irq0_reg <= |fire0;
      irq1_reg <= |fire1;
      ps_reg <= ps_fire;
    end
  end

  assign msr_rdata_o = rdata_reg;
  assign msr_ack_o = ack_reg;
  assign irq_lp0_o = irq0_reg;
  assign irq_lp1_o = irq1_reg;
  assign ps_sample_o = ps_reg;
  assign ovf_flag_o = {cfg_q[1].ovf, cfg_q[0].ovf};

endmodule : tqec_ctrl

// ==== test/tqec_ctrl_monitor.sv ====
// Concurrent checks on the counter control block, seen from its ports.
// Assumes one clock domain and config writes that land the next cycle.
`timescale 1ns/1ps

module tqec_ctrl_monitor
  import tqec_pkg::*;
#(
  parameter int CNT_W = 40,
  parameter int NSEL = 8
) (
  input wire logic mclk_i,              // Core clock
  input wire logic resetn_i,            // Async reset, active low
  input wire tqec_msr_t msr_i,          // Register request
  input wire logic [63:0] msr_rdata_o,  // Read data
  input wire logic msr_ack_o,           // Request done
  input wire logic irq_lp0_o,           // Interrupt to lp0
  input wire logic irq_lp1_o,           // Interrupt to lp1
  input wire logic [1:0] ps_sample_o,   // Sample pulses
  input wire logic [1:0] ovf_flag_o     // Sticky flags
);
  logic [63:0] cfg0_reg;
  logic [63:0] cfg1_reg;
  wire wr0 = msr_i.wr && msr_i.addr == ADDR_CFG0;
  wire wr1 = msr_i.wr && msr_i.addr == ADDR_CFG1;
  wire rd0 = msr_i.rd && !msr_i.wr && msr_i.addr == ADDR_CFG0;
  wire [1:0] clr = {wr1, wr0} & {2{!msr_i.wdata[OVF_BIT]}};
  wire [63:0] irq_bits = cfg0_reg | cfg1_reg;

  // Shadow of what software wrote; hardware can also set the flag bit
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg0_reg <= 64'h0;
      cfg1_reg <= 64'h0;
    end else begin
      cfg0_reg <= wr0 ? msr_i.wdata : cfg0_reg;
      cfg1_reg <= wr1 ? msr_i.wdata : cfg1_reg;
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  ack_follows_req_a: assert property (
    msr_ack_o == $past(msr_i.wr | msr_i.rd)) else $error("bad ack");
  flag_stays_set_a: assert property (
    (($past(ovf_flag_o) & ~$past(clr)) & ~ovf_flag_o) == 2'h0)
    else $error("flag dropped");
  flag_needs_en_a: assert property (
    $rose(ovf_flag_o[0]) && !$past(wr0) |-> $past(cfg0_reg[EN_BIT]))
    else $error("overflow while disabled");
  irq0_gated_a: assert property (
    irq_lp0_o |-> $past(irq_bits[IRQ0_BIT])) else $error("stray irq0");
  irq1_gated_a: assert property (
    irq_lp1_o |-> $past(irq_bits[IRQ1_BIT])) else $error("stray irq1");
  irq_after_wrap_a: assert property (
    (irq_lp0_o || irq_lp1_o) |-> $past(ovf_flag_o != 2'h0))
    else $error("irq in wrap cycle");
  sample_on_ovf_a: assert property (
    (ps_sample_o & ~ovf_flag_o) == 2'h0) else $error("sample no ovf");
  cfg_readback_a: assert property (
    rd0 |=> (msr_rdata_o & 64'hffff_ffff_7fff_ffff)
      == (cfg0_reg & 64'h4fff_f000)) else $error("cfg readback");

  lp0_irq_c: cover property (irq_lp0_o);
  lp1_irq_c: cover property (irq_lp1_o);
  sample_c: cover property (ps_sample_o[0]);
endmodule : tqec_ctrl_monitor

bind tqec_ctrl tqec_ctrl_monitor #(.CNT_W(CNT_W), .NSEL(NSEL)) u_mon (
  .mclk_i(mclk_i), .resetn_i(resetn_i), .msr_i(msr_i),
  .msr_rdata_o(msr_rdata_o), .msr_ack_o(msr_ack_o),
  .irq_lp0_o(irq_lp0_o), .irq_lp1_o(irq_lp1_o),
  .ps_sample_o(ps_sample_o), .ovf_flag_o(ovf_flag_o));

// ==== test/tqec_src.sv ====
// Behavioural event sources and the two logical processors.
// Assumes the bench changes its levels on the rising clock edge.
`timescale 1ns/1ps

module tqec_src
  import tqec_pkg::*;
#(
  parameter int NSEL = 8
) (
  input wire logic [2:0] pick_i,  // Selector carrying events
  input wire logic [3:0] qual_i,  // Qualifier bits
  input wire logic ti_i,          // Thread independent event
  input wire logic [3:0] cnt_i,   // Per-cycle count
  input wire logic [1:0] kern_i,  // Kernel level per slot
  input wire logic [1:0] halt_i,  // Halted per slot
  input wire logic [1:0] startup_interprocessor_interrupt_i,  // Waiting for startup per slot
  input wire logic swap_i,        // Exchange the two initial IDs
  output tqec_slot_t slot_o [2],  // Processor state
  output tqec_sel_t sel_o [NSEL]  // Event selectors
);
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      slot_o[i].interrupt_controller_unit_id = 8'(i) ^ {7'h0, swap_i};
      slot_o[i].halted = halt_i[i];
      slot_o[i].wait_startup_interprocessor_interrupt = startup_interprocessor_interrupt_i[i];
      slot_o[i].kernel = kern_i[i];
    end
    for (int i = 0; i < NSEL; i++) begin
      // Idle selectors carry nothing, so a wrong pick counts zero
      sel_o[i] = '0;
      if (3'(i) == pick_i) begin
        sel_o[i] = '{qual_i, ti_i, 1'b1, cnt_i, cnt_i, cnt_i};
      end
    end
  end
endmodule : tqec_src

// ==== test/testbench.sv ====
// Self-checking bench: register traffic plus steered event sources.
// Assumes every request is acked exactly one cycle after it is taken.
`timescale 1ns/1ps

module testbench
  import tqec_pkg::*;
;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  tqec_msr_t msr = '0;
  logic [63:0] rdata;
  logic ack, irq0, irq1;
  logic [1:0] ps, ovf;
  tqec_slot_t slot [2];
  tqec_sel_t sel [8];
  logic [2:0] pick = 3'h3;
  logic [3:0] qual = 4'h0;
  logic [3:0] cnt = 4'h0;
  logic ti = 1'b0;
  logic [1:0] kern = 2'h0;
  logic [1:0] halt = 2'h0;
  logic [1:0] startup_interprocessor_interrupt = 2'h0;
  logic swap = 1'b0;
  logic [7:0] sid = 8'h0;
  logic [7:0] n_i0 = 8'h0, n_i1 = 8'h0, n_p0 = 8'h0, n_p1 = 8'h0;
  int errors = 0;
  int num_checks = 0;
  logic [63:0] d;
  logic [11:0] ra [5] = '{ADDR_CFG0, ADDR_CFG1, ADDR_CNT0, ADDR_PSEN, 12'h123};
  logic [3:0] hsv [3] = '{4'hc, 4'h2, 4'h0};
  // Last entry: complement with compare on, idle cycles also count
  logic [63:0] cmpv [5] = '{64'h2b_7000, 64'h27_7000, 64'h37_7000,
                            64'h127_7000, 64'h2f_7000};
  logic [63:0] cmpe [5] = '{64'hc, 64'h4, 64'h0, 64'h1, 64'h2};

  always #12.5 mclk_i = ~mclk_i;

  tqec_ctrl #(.CNT_W(40), .NSEL(8)) u_tqec_ctrl (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .msr_i(msr),
    .msr_rdata_o(rdata), .msr_ack_o(ack), .slot_i(slot), .sel_i(sel),
    .irq_lp0_o(irq0), .irq_lp1_o(irq1), .ps_sample_o(ps),
    .ovf_flag_o(ovf));
  tqec_src #(.NSEL(8)) u_tqec_src (
    .pick_i(pick), .qual_i(qual), .ti_i(ti), .cnt_i(cnt), .kern_i(kern),
    .halt_i(halt), .startup_interprocessor_interrupt_i(startup_interprocessor_interrupt), .swap_i(swap), .slot_o(slot),
    .sel_o(sel));

  always @(posedge mclk_i) begin
    n_i0 <= n_i0 + 8'(irq0 === 1'b1);
    n_i1 <= n_i1 + 8'(irq1 === 1'b1);
    n_p0 <= n_p0 + 8'(ps[0] === 1'b1);
    n_p1 <= n_p1 + 8'(ps[1] === 1'b1);
  end

  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [63:0] v);
    @(posedge mclk_i);
    msr <= '{1'b1, 1'b0, a, v, sid};
    @(posedge mclk_i);
    msr.wr <= 1'b0;
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [63:0] e);
    @(posedge mclk_i);
    msr <= '{1'b0, 1'b1, a, 64'h0, sid};
    @(posedge mclk_i);
    msr.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rc

  // x is {kernel mask, thread independent, qualifiers}; four counts of c
  task automatic run(input logic [6:0] x, input logic [3:0] hs,
                     input logic [3:0] c, input logic [63:0] b,
                     input logic [63:0] e);
    wr(ADDR_CNT0, b);
    @(posedge mclk_i);
    {kern, ti, qual} <= x;
    {halt, startup_interprocessor_interrupt} <= hs;
    cnt <= c;
    repeat (4) @(posedge mclk_i);
    cnt <= 4'h0;
    rc(ADDR_CNT0, e);
  endtask : run

  function automatic logic [63:0] qexp(input logic [6:0] x);
    logic [1:0] m;
    m = {x[3] | x[1], x[2] | x[0]};
    if (x[4]) begin
      return (m == 2'h3 || (m[1] && x[6:5] != 2'h0) ||
              (m[0] && x[6:5] != 2'h3)) ? 64'h8 : 64'h0;
    end
    return ((x[5] ? x[3] : x[2]) ? 64'h8 : 64'h0)
      + ((x[6] ? x[1] : x[0]) ? 64'h8 : 64'h0);
  endfunction : qexp

  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // About fourteen times the fourteen hundred cycles the tests need
  initial begin
    #500000;
    errors++;
    give_verdict();
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    resetn_i <= 1'b1;
    wr(12'h123, '1);
    foreach (ra[i]) rc(ra[i], 64'h0);
    wr(ADDR_CFG0, 64'hffff_ffff_ffff_efff);
    rc(ADDR_CFG0, 64'hcfff_e000);
    chk(64'(ovf), 64'h1);
    wr(ADDR_CFG0, 64'h0);
    rc(ADDR_CFG0, 64'h0);
    chk(64'(ovf), 64'h0);
    wr(ADDR_CFG0, 64'h37000);
    for (int i = 0; i < 128; i++) begin
      run(7'(i), 4'h0, 4'h2, 64'h0, qexp(7'(i)));
    end
    // Swapped IDs: thread 0 now sits in slot 1
    @(posedge mclk_i);
    swap <= 1'b1;
    run(7'h28, 4'h0, 4'h2, 64'h0, 64'h0);
    run(7'h48, 4'h0, 4'h2, 64'h0, 64'h8);
    @(posedge mclk_i);
    swap <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      wr(ADDR_CFG0, 64'h7000 | (64'(a) << ACT_LSB));
      for (int s = 0; s < 3; s++) begin
        d = ((a == 3) ? (s != 0) : (a == s)) ? 64'h8 : 64'h0;
        run(7'h3f, hsv[s], 4'h2, 64'h0, d);
      end
    end
    wr(ADDR_CFG0, 64'h36000);
    run(7'h3f, 4'h0, 4'h2, 64'h0, 64'h0);
    wr(ADDR_CFG0, 64'h3b000);
    run(7'h3f, 4'h0, 4'h2, 64'h0, 64'h0);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CFG0, cmpv[i]);
      run(7'h3f, 4'h0, 4'h3, 64'h0, cmpe[i]);
    end
    wr(ADDR_CFG0, 64'h803_7000);
    run(7'h3f, 4'h0, 4'h1, 64'hffff_ffff_ffff_fffe, 64'h2);
    chk(64'({n_i0, n_i1, n_p0}), 64'h00_0100);
    wr(ADDR_PSEN, 64'h200_0000);
    sid = 8'h1;
    rc(ADDR_PSEN, 64'h400_0000);
    sid = 8'h0;
    wr(ADDR_CFG1, 64'h4003_7000);
    wr(ADDR_CFG0, 64'h603_7000);
    run(7'h3f, 4'h0, 4'h1, 64'h0, 64'h4);
    rc(ADDR_CNT1, 64'h3);
    chk(64'({n_i0, n_i1, n_p0, n_p1}), 64'h0301_0400);
    chk(64'(ovf), 64'h1);
    give_verdict();
  end
endmodule : testbench
